//--- rtl/aalu_pkg.sv
package aalu_pkg;

  // widths
  localparam int DATA_W   = 8;
  localparam int INSTR_W  = 14;
  localparam int NIBBLE_W = 4;
  localparam int ADDR_W   = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ACC   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FREG  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h0C;

  // opcode fields
  localparam logic [4:0] OPC_IMM_SUM  = 5'h1F; // 11 111x
  localparam logic [5:0] OPC_REG_SUM  = 6'h07; // 00 0111
  localparam logic [5:0] OPC_IMM_MASK = 6'h39; // 11 1001
  localparam int         DEST_BIT     = 7;

  // status bit positions
  localparam int STAT_C    = 0;
  localparam int STAT_DC   = 1;
  localparam int STAT_Z    = 2;
  localparam int STAT_BUSY = 3;

  // reset values
  localparam logic [DATA_W-1:0]  RST_DATA  = 8'h00;
  localparam logic [INSTR_W-1:0] RST_INSTR = 14'h0000;
  localparam logic [31:0]        RST_RDATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4
  } aalu_phase_t;

  typedef enum logic [1:0] {
    OP_NONE, OP_IMM_SUM, OP_REG_SUM, OP_IMM_MASK
  } aalu_op_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } aalu_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } aalu_apb_rsp_t;

  typedef struct packed {
    aalu_phase_t        ph;
    aalu_op_t           op;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0]  acc;
    logic [DATA_W-1:0]  freg;
    logic [DATA_W-1:0]  opnd;
    logic [DATA_W-1:0]  res;
    logic               c;
    logic               dc;
    logic               z;
    logic               rc;
    logic               rdc;
    logic [31:0]        prdata;
  } aalu_state_t;

endpackage

//--- rtl/aalu_add8.sv
`timescale 1ns/1ps
module aalu_add8
  import aalu_pkg::*;
#(
  parameter int W    = DATA_W,
  parameter int HALF = NIBBLE_W
) (
  // operands
  input  logic [W-1:0] a,
  input  logic [W-1:0] b,
  // result and carries
  output logic [W-1:0] sum,
  output logic         carry,
  output logic         half_carry
);
  logic [W:0]    full;
  logic [HALF:0] low;

  // carry out of top bit and of low nibble
  always_comb begin
    full       = {1'b0, a} + {1'b0, b};
    low        = {1'b0, a[HALF-1:0]} + {1'b0, b[HALF-1:0]};
    sum        = full[W-1:0];
    carry      = full[W];
    half_carry = low[HALF];
  end
endmodule // aalu_add8

//--- rtl/aalu_core.sv
`timescale 1ns/1ps
module aalu_core (
  // clock and reset
  input  logic                    clk_sys,
  input  logic                    rst,
  // register bus
  input  aalu_pkg::aalu_apb_req_t apb_req,
  output aalu_pkg::aalu_apb_rsp_t apb_rsp,
  // core status
  output logic                    busy
);
  import aalu_pkg::*;

  aalu_state_t       st_r;
  aalu_state_t       st_nxt;
  logic [DATA_W-1:0] ad_sum;
  logic              ad_c;
  logic              ad_dc;
  logic              setup;
  logic              access;
  logic              hit;
  logic              stall;
  logic              wr_s;
  logic [31:0]       rd_mux;

  // adder shared by both sum operations
  aalu_add8 u_add (
    .a          (st_r.acc),
    .b          (st_r.opnd),
    .sum        (ad_sum),
    .carry      (ad_c),
    .half_carry (ad_dc)
  );

  // apb decode; writes wait while an instruction runs
  always_comb begin
    setup  = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable;
    hit    = (apb_req.paddr == OFS_INSTR) || (apb_req.paddr == OFS_ACC) ||
             (apb_req.paddr == OFS_FREG) || (apb_req.paddr == OFS_STAT);
    busy   = (st_r.ph != PH_IDLE);
    stall  = busy && apb_req.pwrite;
    wr_s   = access && apb_req.pwrite && !stall && hit;
    apb_rsp.pready  = !stall;
    apb_rsp.pslverr = access && !stall && !hit;
    apb_rsp.prdata  = st_r.prdata;
  end

  // read data selection
  always_comb begin
    rd_mux = RST_RDATA;
    unique case (apb_req.paddr)
      OFS_INSTR: rd_mux = {{(32-INSTR_W){1'b0}}, st_r.instr};
      OFS_ACC:   rd_mux = {{(32-DATA_W){1'b0}}, st_r.acc};
      OFS_FREG:  rd_mux = {{(32-DATA_W){1'b0}}, st_r.freg};
      OFS_STAT: begin
        rd_mux[STAT_C]    = st_r.c;
        rd_mux[STAT_DC]   = st_r.dc;
        rd_mux[STAT_Z]    = st_r.z;
        rd_mux[STAT_BUSY] = busy;
      end
      default:   rd_mux = RST_RDATA;
    endcase
  end

  // next state: bus writes and the phase sequencer
  always_comb begin
    st_nxt = st_r;
    if (setup && !apb_req.pwrite) begin
      st_nxt.prdata = rd_mux;
    end
    // four phases per instruction
    // phase sequencing
    unique case (st_r.ph)
      PH_IDLE: begin
        if (wr_s) begin
          unique case (apb_req.paddr)
            OFS_INSTR: begin
              st_nxt.instr = apb_req.pwdata[INSTR_W-1:0];
              st_nxt.ph    = PH_Q1;
            end
            OFS_ACC:  st_nxt.acc  = apb_req.pwdata[DATA_W-1:0];
            OFS_FREG: st_nxt.freg = apb_req.pwdata[DATA_W-1:0];
            default: begin
              st_nxt.c  = apb_req.pwdata[STAT_C];
              st_nxt.dc = apb_req.pwdata[STAT_DC];
              st_nxt.z  = apb_req.pwdata[STAT_Z];
            end
          endcase
        end
      end
      PH_Q1: begin
        // decode; other opcodes pass as no-ops
        if (st_r.instr[13:9] == OPC_IMM_SUM) begin
          st_nxt.op = OP_IMM_SUM;
        end else if (st_r.instr[13:8] == OPC_REG_SUM) begin
          st_nxt.op = OP_REG_SUM;
        end else if (st_r.instr[13:8] == OPC_IMM_MASK) begin
          st_nxt.op = OP_IMM_MASK;
        end else begin
          st_nxt.op = OP_NONE;
        end
        st_nxt.ph = PH_Q2;
      end
      PH_Q2: begin
        // operand read: file register or immediate
        // file operand
        if (st_r.op == OP_REG_SUM) begin
          st_nxt.opnd = st_r.freg;
        end else begin
          st_nxt.opnd = st_r.instr[DATA_W-1:0];
        end
        st_nxt.ph = PH_Q3;
      end
      PH_Q3: begin
        // process
        // bitwise mask
        if (st_r.op == OP_IMM_MASK) begin
          st_nxt.res = st_r.acc & st_r.opnd;
        end else begin
          st_nxt.res = ad_sum;
        end
        st_nxt.rc  = ad_c;
        st_nxt.rdc = ad_dc;
        st_nxt.ph  = PH_Q4;
      end
      PH_Q4: begin
        // write-back and flags
        unique case (st_r.op)
          OP_IMM_SUM: begin
            st_nxt.acc = st_r.res;
            st_nxt.c   = st_r.rc;
            st_nxt.dc  = st_r.rdc;
            st_nxt.z   = (st_r.res == RST_DATA);
          end
          OP_REG_SUM: begin
            if (st_r.instr[DEST_BIT]) begin
              st_nxt.freg = st_r.res;
            end else begin
              st_nxt.acc = st_r.res;
            end
            st_nxt.c  = st_r.rc;
            st_nxt.dc = st_r.rdc;
            st_nxt.z  = (st_r.res == RST_DATA);
          end
          OP_IMM_MASK: begin
            st_nxt.acc = st_r.res;
            st_nxt.z   = (st_r.res == RST_DATA);
          end
          OP_NONE: st_nxt.acc = st_r.acc;
        endcase
        st_nxt.ph = PH_IDLE;
      end
      default: st_nxt.ph = PH_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r.ph     <= PH_IDLE;
      st_r.op     <= OP_NONE;
      st_r.instr  <= RST_INSTR;
      st_r.acc    <= RST_DATA;
      st_r.freg   <= RST_DATA;
      st_r.opnd   <= RST_DATA;
      st_r.res    <= RST_DATA;
      st_r.c      <= 1'b0;
      st_r.dc     <= 1'b0;
      st_r.z      <= 1'b0;
      st_r.rc     <= 1'b0;
      st_r.rdc    <= 1'b0;
      st_r.prdata <= RST_RDATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [DATA_W-1:0] chk_sum;
  logic [DATA_W-1:0] chk_and;
  always_comb begin
    chk_sum = st_r.acc + st_r.opnd;
    chk_and = st_r.acc & st_r.opnd;
  end

  sequence s_start;
    wr_s && (apb_req.paddr == OFS_INSTR);
  endsequence
  sequence s_quad;
    ##1 st_r.ph == PH_Q1 ##1 st_r.ph == PH_Q2 ##1 st_r.ph == PH_Q3
    ##1 st_r.ph == PH_Q4 ##1 st_r.ph == PH_IDLE;
  endsequence
  sequence s_proc(aalu_op_t o);
    st_r.ph == PH_Q3 && st_r.op == o;
  endsequence
  sequence s_dest(logic d);
    st_r.ph == PH_Q3 && st_r.op == OP_REG_SUM && st_r.instr[DEST_BIT] == d;
  endsequence

  AST_IMM_SUM: assert property (
    s_proc(OP_IMM_SUM) |-> ##2 (st_r.acc == $past(chk_sum, 2)) &&
      (st_r.c == $past(ad_c, 2)))
    else $error("immediate sum result wrong");
  AST_REG_FLAGS: assert property (
    s_proc(OP_REG_SUM) |-> ##2 (st_r.c == $past(ad_c, 2)) &&
      (st_r.dc == $past(ad_dc, 2)))
    else $error("register sum flags wrong");
  AST_DEST_ACC: assert property (
    s_dest(1'b0) |->
      ##2 (st_r.acc == $past(chk_sum, 2)) && $stable(st_r.freg))
    else $error("register sum to accumulator wrong");
  AST_DEST_FREG: assert property (
    s_dest(1'b1) |->
      ##2 (st_r.freg == $past(chk_sum, 2)) && $stable(st_r.acc))
    else $error("register sum to file register wrong");
  AST_MASK: assert property (
    s_proc(OP_IMM_MASK) |-> ##2 (st_r.acc == $past(chk_and, 2)) &&
      (st_r.c == $past(st_r.c, 2)) && (st_r.dc == $past(st_r.dc, 2)))
    else $error("immediate mask wrong");
  AST_QUAD: assert property (s_start |-> s_quad)
    else $error("phase sequence wrong");
  AST_ZERO: assert property (
    (s_proc(OP_IMM_SUM) or s_proc(OP_REG_SUM)) |->
      ##2 st_r.z == ($past(chk_sum, 2) == RST_DATA))
    else $error("zero flag wrong");
  AST_UNMAPPED: assert property (
    (access && !hit && !stall) |-> apb_rsp.pslverr && apb_rsp.pready)
    else $error("unmapped access not flagged");
endmodule // aalu_core

//--- sim/aalu_host.sv
`timescale 1ns/1ps
module aalu_host (
  // clock
  input  logic                    clk_sys,
  // register bus toward the core
  output aalu_pkg::aalu_apb_req_t apb_req,
  input  aalu_pkg::aalu_apb_rsp_t apb_rsp
);
  import aalu_pkg::*;

  // bus idle until the first transfer
  initial apb_req = '0;

  // one transfer, request held until pready is seen high or 20 cycles pass
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e, output logic ok);
    int n;
    n = 0;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    ok = (apb_rsp.pready === 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
endmodule // aalu_host

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import aalu_pkg::*;

  // clock, reset and design signals
  logic          clk_sys = 1'b0;
  logic          rst = 1'b1;
  aalu_apb_req_t apb_req;
  aalu_apb_rsp_t apb_rsp;
  logic          busy;
  // bookkeeping
  int            err_total = 0;
  int            n_tests = 0;
  int            nb;
  logic [31:0]   q;
  logic          e;
  logic          ok;
  logic [13:0]   ins;

  always #12.5 clk_sys = ~clk_sys;

  aalu_core aalu_core_i (.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req),
                         .apb_rsp(apb_rsp), .busy(busy));
  aalu_host aalu_host_i (.clk_sys(clk_sys), .apb_req(apb_req),
                         .apb_rsp(apb_rsp));

  // verdict and end of run
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // bus access, a hang ends the run
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    aalu_host_i.xfer(wr, a, d, q, e, ok);
    if (!ok) begin
      err_total++;
      summarize();
    end
  endtask

  // expected {acc, freg, z dc c} after one instruction
  function automatic logic [18:0] model(input logic [13:0] i,
      input logic [7:0] a, input logic [7:0] f, input logic [2:0] s);
    logic [8:0] sum;
    logic [4:0] lo;
    logic [7:0] b;
    b = (i[13:8] == OPC_REG_SUM) ? f : i[7:0];
    sum = {1'b0, a} + {1'b0, b};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    if (i[13:9] == OPC_IMM_SUM || i[13:8] == OPC_REG_SUM) begin
      s = {sum[7:0] == 8'h00, lo[4], sum[8]};
      if (i[13:8] == OPC_REG_SUM && i[DEST_BIT]) f = sum[7:0];
      else a = sum[7:0];
    end else if (i[13:8] == OPC_IMM_MASK) begin
      a = a & i[7:0];
      s[STAT_Z] = (a == 8'h00);
    end
    return {a, f, s};
  endfunction

  // load state, execute, count busy cycles, read back
  task automatic run(input logic [13:0] i, input logic [7:0] a,
                     input logic [7:0] f, input logic [2:0] s);
    logic [18:0] x;
    x = model(i, a, f, s);
    bus(1'b1, OFS_ACC, {24'h0, a});
    bus(1'b1, OFS_FREG, {24'h0, f});
    bus(1'b1, OFS_STAT, {29'h0, s});
    bus(1'b1, OFS_INSTR, {18'h0, i});
    nb = 0;
    repeat (8) begin
      @(posedge clk_sys);
      nb += int'(busy === 1'b1);
    end
    chk(32'(nb), 32'h4);
    bus(1'b0, OFS_ACC, 32'h0);
    chk(q, {24'h0, x[18:11]});
    bus(1'b0, OFS_FREG, 32'h0);
    chk(q, {24'h0, x[10:3]});
    bus(1'b0, OFS_STAT, 32'h0);
    chk(q, {29'h0, x[2:0]});
  endtask

  // status read and a stalled write while a register sum runs
  task automatic overlap(input logic [7:0] a, input logic [7:0] f);
    logic [18:0] x;
    logic [18:0] y;
    x = model(14'h0780, a, f, 3'h0);
    y = model(14'h0780, a, x[10:3], x[2:0]);
    bus(1'b1, OFS_ACC, {24'h0, a});
    bus(1'b1, OFS_FREG, {24'h0, f});
    bus(1'b1, OFS_STAT, 32'h0);
    bus(1'b1, OFS_INSTR, 32'h0780);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(q, 32'h8);
    repeat (8) @(posedge clk_sys);
    bus(1'b0, OFS_FREG, 32'h0);
    chk(q, {24'h0, x[10:3]});
    bus(1'b1, OFS_INSTR, 32'h0780);
    bus(1'b1, OFS_FREG, {24'h0, ~f});
    bus(1'b0, OFS_FREG, 32'h0);
    chk(q, {24'h0, ~f});
    bus(1'b0, OFS_ACC, 32'h0);
    chk(q, {24'h0, y[18:11]});
    bus(1'b0, OFS_STAT, 32'h0);
    chk(q, {29'h0, y[2:0]});
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h42EA));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int r = 4; r < 16; r += 4) begin
      bus(1'b0, 8'(r), 32'h0);
      chk(q, RST_RDATA);
    end
    bus(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    run(14'h3E15, 8'h10, 8'h00, 3'h0);
    run(14'h3FFF, 8'h01, 8'h00, 3'h0);
    run(14'h0704, 8'h17, 8'hC2, 3'h7);
    run(14'h0784, 8'h0F, 8'hF1, 3'h0);
    run(14'h395F, 8'hA3, 8'h00, 3'h3);
    run(14'h3900, 8'h5A, 8'h00, 3'h3);
    run(14'h0800, 8'h33, 8'h44, 3'h5);
    overlap(8'h2B, 8'h19);
    repeat (40) begin
      ins = 14'($urandom);
      case ($urandom_range(3))
        0: ins = {5'h1F, ins[8:0]};
        1: ins = {6'h07, ins[7:0]};
        2: ins = {6'h39, ins[7:0]};
        default: ins = {6'h08, ins[7:0]};
      endcase
      run(ins, 8'($urandom), 8'($urandom), 3'($urandom));
    end
    summarize();
  end
endmodule // testbench
